// [hdl/cmd_pkg.sv]
// Constants for the serial command interpreter of the PWM evaluation board
// ****************************************
// ****************************************
package cmd_pkg;
   // Clock and link timing
   localparam int unsigned CLK_HZ = 250_000_000;
   localparam int unsigned BAUD_RATE = 9600;
   localparam int unsigned BIT_CYC = CLK_HZ / BAUD_RATE;
   // Packet bytes
   localparam logic [7:0] BOARD_ADDR = 8'h02;
   localparam logic [7:0] TERM_BYTE = 8'h0a;
   localparam logic [2:0] REQ_LAST = 3'h4;
   localparam logic [2:0] RESP_LEN = 3'h6;
   // Opcodes
   localparam logic [7:0] OP_VER1 = 8'h05;
   localparam logic [7:0] OP_VER2 = 8'h06;
   localparam logic [7:0] OP_DEAD = 8'h10;
   localparam logic [7:0] OP_WIDTH = 8'h20;
   localparam logic [7:0] OP_RES = 8'h30;
   localparam logic [7:0] OP_ENABLE = 8'h40;
   localparam logic [7:0] OP_RESET = 8'h50;
   localparam logic [7:0] OP_DIV = 8'h60;
   localparam logic [7:0] OP_LOCK = 8'h70;
   localparam logic [7:0] OP_CSEL = 8'h80;
   localparam logic [7:0] OP_RD_WIDTH = 8'h90;
   localparam logic [7:0] OP_RD_RES = 8'h93;
   localparam logic [7:0] OP_RD_LOCK = 8'h94;
   localparam logic [7:0] OP_RD_DIV = 8'h95;
   localparam logic [7:0] OP_RD_EN = 8'h96;
   // Error codes
   localparam logic [7:0] ERR_NONE = 8'h00;
   localparam logic [7:0] ERR_TIMING = 8'he0;
   localparam logic [7:0] ERR_OPCODE = 8'he1;
   localparam logic [7:0] ERR_LOCKED = 8'he2;
   // Microprocessor clock range and power-on settings
   localparam logic [7:0] FREQ_MAX = 8'h32;
   localparam logic [7:0] DEAD_RST = 8'h00;
   localparam logic [7:0] WIDTH_RST = 8'h00;
   localparam logic [31:0] NCO_BASE7 = 32'h0000_0100;
   localparam logic [31:0] NCO_BASE8 = 32'h0000_0200;
   // Register offsets
   localparam logic [7:0] REG_STATUS = 8'h00;
   localparam logic [7:0] REG_IEN = 8'h04;
   localparam logic [7:0] REG_ICLR = 8'h08;
   localparam logic [7:0] REG_SETTINGS = 8'h0c;
   // Event bit positions
   localparam int EV_DONE = 0;
   localparam int EV_ERROR = 1;
   localparam int EV_DROP = 2;
   localparam int EV_W = 3;
endpackage

// [hdl/pwm_cmd_interp.sv]
// Serial command interpreter for the two-output PWM controller board
`timescale 1ns/1ns
module pwm_cmd_interp #(
   parameter int unsigned BIT_CYCLES = cmd_pkg::BIT_CYC,
   parameter logic [7:0] VERSION1 = 8'h01, // Arbitrary value
   parameter logic [7:0] VERSION2 = 8'h00  // Arbitrary value
) (
   // Clock, reset, enable
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Serial link
   input wire logic rxd_i,
   output logic txd_o,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic irq_o,
   // Controller settings
   output logic [7:0] dead_time_o,
   output logic [7:0] pulse_width_o,
   output logic res7_o,
   output logic stop_o,
   output logic clk_div2_o,
   output logic lock_o,
   output logic clk_sel_uproc_o,
   output logic uproc_clk_o
);
   // ****************************************
   // Types and state
   // ****************************************
   typedef enum logic [1:0] {
      RX_IDLE = 2'b00,
      RX_START = 2'b01,
      RX_DATA = 2'b10,
      RX_STOP = 2'b11
   } rx_state_type;
   typedef enum logic [1:0] {
      COLLECT = 2'b00,
      EXEC = 2'b01,
      SEND = 2'b10
   } cmd_state_type;

   localparam logic [15:0] BIT_LEN = 16'(BIT_CYCLES - 1);
   localparam logic [15:0] HALF_LEN = 16'(BIT_CYCLES / 2);

   logic rx_meta_ff, rx_sync_ff;
   rx_state_type rx_st_ff;
   logic [15:0] rx_cnt_ff;
   logic [2:0] rx_bit_ff;
   logic [7:0] rx_sh_ff;
   logic rx_done_ff, rx_ferr_ff;
   cmd_state_type st_ff;
   logic [7:0] pkt_ff [0:4];
   logic [2:0] idx_ff;
   logic corrupt_ff, overrun_ff;
   logic [7:0] resp_ff [0:5];
   logic [2:0] sidx_ff;
   logic tx_busy_ff;
   logic [9:0] tx_sh_ff;
   logic [15:0] tx_cnt_ff;
   logic [3:0] tx_bits_ff;
   logic [7:0] dead_ff, pw_ff, freq_ff;
   logic res7_ff, en_ff, div_ff, lock_ff, csel_ff;
   logic [31:0] nco_ff;
   logic uclk_ff;
   logic [cmd_pkg::EV_W-1:0] sts_ff, ien_ff;
   logic ack_ff;
   logic [31:0] rdat_ff;

   // ****************************************
   // Receiver
   // ****************************************
   // Two-stage synchroniser on the serial input
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_meta_ff <= 1'b1;
         rx_sync_ff <= 1'b1;
      end else if (ce_i) begin
         rx_meta_ff <= rxd_i;
         rx_sync_ff <= rx_meta_ff;
      end
   end

   wire rx_tick = (rx_cnt_ff == 16'h0000);
   wire rx_center = (rx_cnt_ff == HALF_LEN);

   // Bit framing at the fixed line rate, sampled mid-bit
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_st_ff <= RX_IDLE;
         rx_cnt_ff <= 16'h0000;
         rx_bit_ff <= 3'h0;
         rx_sh_ff <= 8'h00;
         rx_done_ff <= 1'b0;
         rx_ferr_ff <= 1'b0;
      end else if (ce_i) begin
         rx_done_ff <= 1'b0;
         rx_cnt_ff <= rx_tick ? BIT_LEN : rx_cnt_ff - 16'h0001;
         unique case (rx_st_ff)
            RX_IDLE: begin
               rx_cnt_ff <= BIT_LEN;
               if (!rx_sync_ff) begin
                  rx_st_ff <= RX_START;
               end
            end
            RX_START: begin
               if (rx_center) begin
                  rx_st_ff <= rx_sync_ff ? RX_IDLE : RX_DATA;
                  rx_cnt_ff <= BIT_LEN;
                  rx_bit_ff <= 3'h0;
               end
            end
            RX_DATA: begin
               if (rx_tick) begin
                  rx_sh_ff <= {rx_sync_ff, rx_sh_ff[7:1]};
                  rx_bit_ff <= rx_bit_ff + 3'h1;
                  if (rx_bit_ff == 3'h7) begin
                     rx_st_ff <= RX_STOP;
                  end
               end
            end
            RX_STOP: begin
               if (rx_tick) begin
                  rx_done_ff <= 1'b1;
                  rx_ferr_ff <= !rx_sync_ff;
                  rx_st_ff <= RX_IDLE;
               end
            end
         endcase
      end
   end

   // ****************************************
   // Packet assembly and command decode
   // ****************************************
   wire [7:0] op = pkt_ff[2];
   wire [7:0] dat = pkt_ff[3];
   wire exec = (st_ff == EXEC);
   wire addr_bad = (idx_ff == 3'h0) && (rx_sh_ff != cmd_pkg::BOARD_ADDR);
   wire last_byte = (idx_ff == cmd_pkg::REQ_LAST);
   wire term_ok = (rx_sh_ff == cmd_pkg::TERM_BYTE);
   wire drop_ev = rx_done_ff && (st_ff == COLLECT) && (addr_bad || (last_byte && !term_ok));
   wire is_lockable = (op == cmd_pkg::OP_DEAD) || (op == cmd_pkg::OP_RES) ||
                      (op == cmd_pkg::OP_DIV) || (op == cmd_pkg::OP_ENABLE);
   wire freq_bad = (op == cmd_pkg::OP_CSEL) && (dat > cmd_pkg::FREQ_MAX);
   logic op_known;
   logic [7:0] rd_data;

   // Opcode recognition and read-back selection
   always_comb begin
      op_known = 1'b1;
      rd_data = dat;
      unique case (op)
         cmd_pkg::OP_VER1: rd_data = VERSION1;
         cmd_pkg::OP_VER2: rd_data = VERSION2;
         cmd_pkg::OP_DEAD, cmd_pkg::OP_WIDTH, cmd_pkg::OP_RES, cmd_pkg::OP_ENABLE,
         cmd_pkg::OP_RESET, cmd_pkg::OP_DIV, cmd_pkg::OP_LOCK, cmd_pkg::OP_CSEL: rd_data = dat;
         cmd_pkg::OP_RD_WIDTH: rd_data = pw_ff;
         cmd_pkg::OP_RD_RES: rd_data = {7'h00, res7_ff};
         cmd_pkg::OP_RD_LOCK: rd_data = {7'h00, lock_ff};
         cmd_pkg::OP_RD_DIV: rd_data = {7'h00, div_ff};
         cmd_pkg::OP_RD_EN: rd_data = {7'h00, en_ff};
         default: op_known = 1'b0;
      endcase
   end

   // Error priority: timing fault, then bad packet, then lock refusal
   wire [7:0] err_code = overrun_ff ? cmd_pkg::ERR_TIMING :
                         (corrupt_ff || !op_known || freq_bad) ? cmd_pkg::ERR_OPCODE :
                         (lock_ff && is_lockable) ? cmd_pkg::ERR_LOCKED :
                         cmd_pkg::ERR_NONE;
   wire do_wr = exec && (err_code == cmd_pkg::ERR_NONE);

   // Request collection and reply sequencing
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_ff <= COLLECT;
         idx_ff <= 3'h0;
         corrupt_ff <= 1'b0;
         overrun_ff <= 1'b0;
         for (int i = 0; i < 5; i++) begin
            pkt_ff[i] <= 8'h00;
         end
         for (int i = 0; i < 6; i++) begin
            resp_ff[i] <= 8'h00;
         end
      end else if (ce_i) begin
         unique case (st_ff)
            COLLECT: begin
               if (rx_done_ff) begin
                  pkt_ff[idx_ff] <= rx_sh_ff;
                  corrupt_ff <= (idx_ff != 3'h0) && (corrupt_ff || rx_ferr_ff);
                  idx_ff <= (addr_bad || last_byte) ? 3'h0 : idx_ff + 3'h1;
                  if (last_byte && term_ok) begin
                     st_ff <= EXEC;
                  end
               end
            end
            EXEC: begin
               resp_ff[0] <= pkt_ff[1];
               resp_ff[1] <= cmd_pkg::BOARD_ADDR;
               resp_ff[2] <= op;
               resp_ff[3] <= rd_data;
               resp_ff[4] <= err_code;
               resp_ff[5] <= cmd_pkg::TERM_BYTE;
               overrun_ff <= 1'b0;
               st_ff <= SEND;
            end
            SEND: begin
               if (rx_done_ff) begin
                  overrun_ff <= 1'b1; // Byte arrived while replying
               end
               if (!tx_busy_ff && (sidx_ff == cmd_pkg::RESP_LEN)) begin
                  st_ff <= COLLECT;
               end
            end
            default: st_ff <= COLLECT;
         endcase
      end
   end

   // ****************************************
   // Settings store
   // ****************************************
   wire wr_op_reset = do_wr && (op == cmd_pkg::OP_RESET);

   // Writes to the controller latches; reset command restores power-on values
   always_ff @(posedge clk_i) begin
      if (rst_i || (ce_i && wr_op_reset)) begin
         dead_ff <= cmd_pkg::DEAD_RST;
         pw_ff <= cmd_pkg::WIDTH_RST;
         res7_ff <= 1'b0;
         en_ff <= 1'b0;
         div_ff <= 1'b0;
         lock_ff <= 1'b0;
         csel_ff <= 1'b0;
         freq_ff <= 8'h00;
      end else if (ce_i && do_wr) begin
         if (op == cmd_pkg::OP_DEAD) dead_ff <= dat;
         if (op == cmd_pkg::OP_WIDTH) pw_ff <= dat;
         if (op == cmd_pkg::OP_RES) res7_ff <= dat[0];
         if (op == cmd_pkg::OP_ENABLE) en_ff <= dat[0];
         if (op == cmd_pkg::OP_DIV) div_ff <= dat[0];
         if (op == cmd_pkg::OP_LOCK) lock_ff <= dat[0];
         if (op == cmd_pkg::OP_CSEL) begin
            csel_ff <= (dat != 8'h00);
            freq_ff <= dat;
         end
      end
   end

   // ****************************************
   // Microprocessor-made controller clock
   // ****************************************
   // Toggle rate is twice the controller clock, which is the base period times output rate, doubled when the clock is halved
   wire [31:0] nco_base = res7_ff ? cmd_pkg::NCO_BASE7 : cmd_pkg::NCO_BASE8;
   wire [31:0] nco_inc = (div_ff ? {nco_base[30:0], 1'b0} : nco_base) * {24'h000000, freq_ff};
   wire [31:0] nco_sum = nco_ff + nco_inc;
   wire nco_wrap = (nco_sum >= cmd_pkg::CLK_HZ);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         nco_ff <= 32'h0000_0000;
         uclk_ff <= 1'b0;
      end else if (ce_i) begin
         if (!csel_ff) begin
            nco_ff <= 32'h0000_0000;
            uclk_ff <= 1'b0;
         end else begin
            nco_ff <= nco_wrap ? nco_sum - cmd_pkg::CLK_HZ : nco_sum;
            uclk_ff <= uclk_ff ^ nco_wrap;
         end
      end
   end

   // ****************************************
   // Transmitter
   // ****************************************
   wire tx_go = (st_ff == SEND) && !tx_busy_ff && (sidx_ff != cmd_pkg::RESP_LEN);

   // Sends the six reply bytes one after another, LSB first
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_busy_ff <= 1'b0;
         tx_sh_ff <= 10'h3ff;
         tx_cnt_ff <= 16'h0000;
         tx_bits_ff <= 4'h0;
         sidx_ff <= 3'h0;
      end else if (ce_i) begin
         if (exec) begin
            sidx_ff <= 3'h0;
         end else if (tx_go) begin
            tx_sh_ff <= {1'b1, resp_ff[sidx_ff], 1'b0};
            tx_busy_ff <= 1'b1;
            tx_cnt_ff <= BIT_LEN;
            tx_bits_ff <= 4'h0;
            sidx_ff <= sidx_ff + 3'h1;
         end else if (tx_busy_ff) begin
            tx_cnt_ff <= tx_cnt_ff - 16'h0001;
            if (tx_cnt_ff == 16'h0000) begin
               tx_cnt_ff <= BIT_LEN;
               tx_sh_ff <= {1'b1, tx_sh_ff[9:1]};
               tx_bits_ff <= tx_bits_ff + 4'h1;
               tx_busy_ff <= (tx_bits_ff != 4'h9);
            end
         end
      end
   end

   // ****************************************
   // Wishbone slave and interrupts
   // ****************************************
   wire bus_req = wb_cyc_i && wb_stb_i && !ack_ff;
   wire bus_wr = bus_req && wb_we_i && wb_sel_i[0];
   wire [cmd_pkg::EV_W-1:0] ev = {drop_ev, exec && (err_code != cmd_pkg::ERR_NONE), exec};
   wire [cmd_pkg::EV_W-1:0] clr = (bus_wr && (wb_adr_i == cmd_pkg::REG_ICLR)) ?
                                  wb_dat_i[cmd_pkg::EV_W-1:0] : '0;
   wire [31:0] settings = {pw_ff, dead_ff, freq_ff, 3'h0, csel_ff, lock_ff, div_ff, en_ff, res7_ff};
   logic [31:0] rd_mux;

   // Read selection; unmapped offsets read zero
   always_comb begin
      unique case (wb_adr_i)
         cmd_pkg::REG_STATUS: rd_mux = {29'h0, sts_ff};
         cmd_pkg::REG_IEN: rd_mux = {29'h0, ien_ff};
         cmd_pkg::REG_SETTINGS: rd_mux = settings;
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // Sticky status where a new event wins over a clear in the same cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sts_ff <= '0;
         ien_ff <= '0;
         ack_ff <= 1'b0;
         rdat_ff <= 32'h0000_0000;
      end else if (ce_i) begin
         sts_ff <= (sts_ff & ~clr) | ev;
         ack_ff <= bus_req;
         rdat_ff <= bus_req ? rd_mux : 32'h0000_0000;
         if (bus_wr && (wb_adr_i == cmd_pkg::REG_IEN)) begin
            ien_ff <= wb_dat_i[cmd_pkg::EV_W-1:0];
         end
      end
   end

   // Output drive
   assign wb_ack_o = ack_ff;
   assign wb_dat_o = rdat_ff;
   assign irq_o = |(sts_ff & ien_ff);
   assign txd_o = tx_busy_ff ? tx_sh_ff[0] : 1'b1;
   assign dead_time_o = dead_ff;
   assign pulse_width_o = pw_ff;
   assign res7_o = res7_ff;
   assign stop_o = !en_ff;
   assign clk_div2_o = div_ff;
   assign lock_o = lock_ff;
   assign clk_sel_uproc_o = csel_ff;
   assign uproc_clk_o = uclk_ff;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i || !ce_i);

   sequence locked_write_s;
      exec && lock_ff && is_lockable && !overrun_ff && !corrupt_ff && op_known;
   endsequence

   locked_refuse_a: assert property (locked_write_s |=> resp_ff[4] == cmd_pkg::ERR_LOCKED &&
      $stable(dead_ff) && $stable(div_ff) && $stable(res7_ff) && $stable(en_ff))
      else $error("locked write not refused");
   reply_header_a: assert property (exec |=> resp_ff[1] == cmd_pkg::BOARD_ADDR &&
      resp_ff[5] == cmd_pkg::TERM_BYTE && resp_ff[2] == $past(op))
      else $error("reply header wrong");
   echo_source_a: assert property (exec |=> resp_ff[0] == $past(pkt_ff[1]))
      else $error("source not echoed");
   bad_opcode_a: assert property (exec && !op_known && !overrun_ff |=>
      resp_ff[4] == cmd_pkg::ERR_OPCODE) else $error("bad opcode not flagged");
   overrun_err_a: assert property (exec && overrun_ff |=> resp_ff[4] == cmd_pkg::ERR_TIMING)
      else $error("timing fault not flagged");
   reset_cmd_a: assert property (exec && op == cmd_pkg::OP_RESET && !overrun_ff && !corrupt_ff
      |=> !lock_ff && pw_ff == cmd_pkg::WIDTH_RST && !en_ff)
      else $error("reset command left settings");
   res_keeps_width_a: assert property (do_wr && op == cmd_pkg::OP_RES |=> $stable(pw_ff))
      else $error("width changed with resolution");
   drop_bad_a: assert property (drop_ev |=> st_ff == COLLECT && idx_ff == 3'h0)
      else $error("bad packet not dropped");
   single_reply_a: assert property (exec |=> st_ff == SEND ##1 tx_busy_ff)
      else $error("reply did not start");
   stop_follow_a: assert property (do_wr && op == cmd_pkg::OP_ENABLE |=> stop_o == !$past(dat[0]))
      else $error("stop bit mismatch");
endmodule

// [tb/serial_host.sv]
// Serial host model that sends request packets and collects reply packets
`timescale 1ns/1ns
module serial_host #(
   parameter int BIT = 16
) (
   // Clock
   input wire logic clk_i,
   // Serial lines
   output logic tx_o,
   input wire logic rx_i
);
   // Line idles high like a pulled-up receiver input
   initial tx_o = 1'b1;

   // Sends one 8N1 frame, LSB first; a low stop bit makes a framing fault
   task automatic send_byte(input logic [7:0] b, input logic stop);
      logic [9:0] fr;
      fr = {stop, b, 1'b0};
      @(posedge clk_i);
      for (int i = 0; i < 10; i++) begin
         tx_o <= fr[i];
         repeat (BIT) @(posedge clk_i);
      end
      tx_o <= 1'b1;
   endtask

   // Sends the five request bytes in order; byte number bad gets a low stop bit
   task automatic send_req(input logic [39:0] pk, input int bad);
      for (int i = 0; i < 5; i++) begin
         send_byte(pk[39-8*i -: 8], i != bad);
      end
   endtask

   // Collects six bytes; got stays low when a start bit fails to come within lim clocks
   task automatic get_reply(input int lim, output logic [47:0] rp, output logic got);
      int n;
      rp = '0;
      got = 1'b0;
      for (int k = 0; k < 6; k++) begin
         n = 0;
         while (rx_i !== 1'b0 && n < lim) begin
            @(posedge clk_i);
            n++;
         end
         if (rx_i !== 1'b0) return;
         repeat (BIT / 2) @(posedge clk_i);
         for (int j = 0; j < 8; j++) begin
            repeat (BIT) @(posedge clk_i);
            rp[40-8*k+j] = rx_i;
         end
         repeat (BIT) @(posedge clk_i);
      end
      got = 1'b1;
   endtask
endmodule

// [tb/tb.sv]
// Testbench for the serial command interpreter
`timescale 1ns/1ns
module tb;
   localparam int BIT = 16;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic ce_i = 1'b1;
   logic rxd_i;
   logic txd_o;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic irq_o;
   logic [7:0] dead_time_o;
   logic [7:0] pulse_width_o;
   logic res7_o;
   logic stop_o;
   logic clk_div2_o;
   logic lock_o;
   logic clk_sel_uproc_o;
   logic uproc_clk_o;
   int failures = 0;
   int n_checks = 0;
   logic [31:0] q;
   logic [47:0] rp;
   logic got;
   logic uclk_q = 1'b0;
   int ugap = 0;
   int n_tog = 0;
   int ugap_last = 0;
   // Made clock half period: 7-bit on a halved clock is 256 clocks, two toggles each, at 50 Hz
   localparam int UGAP = cmd_pkg::CLK_HZ / (512 * 50);
   // Row layout: opcode, request data, reply data, reply error
   logic [31:0] rows [24] = '{
      32'h05000100, 32'h06000000, 32'h20808000, 32'h10050500,
      32'h30010100, 32'h90008000, 32'h93000100, 32'h20404000,
      32'h40010100, 32'h96000100, 32'h60010100, 32'h95000100,
      32'h80323200, 32'h803300e1, 32'h70010100, 32'h94000100,
      32'h100700e2, 32'h300000e2, 32'h400000e2, 32'h600000e2,
      32'h20c0c000, 32'h70000000, 32'h94000000, 32'h330000e1};

   always #2 clk_i = ~clk_i;

   pwm_cmd_interp #(.BIT_CYCLES(BIT)) i_pwm_cmd_interp (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .rxd_i(rxd_i), .txd_o(txd_o),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .irq_o(irq_o), .dead_time_o(dead_time_o), .pulse_width_o(pulse_width_o),
      .res7_o(res7_o), .stop_o(stop_o), .clk_div2_o(clk_div2_o), .lock_o(lock_o),
      .clk_sel_uproc_o(clk_sel_uproc_o), .uproc_clk_o(uproc_clk_o));

   serial_host #(.BIT(BIT)) i_serial_host (.clk_i(clk_i), .tx_o(rxd_i), .rx_i(txd_o));

   // Measures the spacing of the made clock's edges while it is selected
   always @(posedge clk_i) begin
      uclk_q <= uproc_clk_o;
      if (!clk_sel_uproc_o) begin
         ugap <= 0;
         n_tog <= 0;
      end else if (uproc_clk_o != uclk_q) begin
         ugap <= 1;
         n_tog <= n_tog + 1;
         if (n_tog > 0) begin
            ugap_last <= ugap;
         end
      end else begin
         ugap <= ugap + 1;
      end
   end

   // Counts one comparison and reports a mismatch
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Prints the counts and the verdict, then stops
   task automatic end_sim();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // One classic Wishbone cycle, held until ack is sampled high
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= 4'hf;
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1 && n < 50) begin
         @(posedge clk_i);
         n++;
      end
      q = wb_dat_o;
      chk("wb ack", 32'h1, {31'h0, wb_ack_o});
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   // Sends one request and checks every byte of its reply, the data byte only when no error is expected
   task automatic cmd(input logic [7:0] src, op, dat, ed, ee, input int bad);
      fork
         i_serial_host.send_req({8'h02, src, op, dat, 8'h0a}, bad);
         i_serial_host.get_reply(BIT * 64, rp, got);
      join
      chk("reply count", 32'h1, {31'h0, got});
      chk("reply dst", {24'h0, src}, {24'h0, rp[47:40]});
      chk("reply src", 32'h2, {24'h0, rp[39:32]});
      chk("reply op", {24'h0, op}, {24'h0, rp[31:24]});
      if (ee == 8'h00) chk("reply data", {24'h0, ed}, {24'h0, rp[23:16]});
      chk("reply err", {24'h0, ee}, {24'h0, rp[15:8]});
      chk("reply term", 32'ha, {24'h0, rp[7:0]});
   endtask

   // Sends a packet that must draw no reply
   task automatic no_reply(input logic [39:0] pk);
      fork
         i_serial_host.send_req(pk, 9);
         i_serial_host.get_reply(BIT * 90, rp, got);
      join
      chk("no reply", 32'h0, {31'h0, got});
   endtask

   // Watchdog cuts a hang short
   initial begin
      repeat (90000) @(posedge clk_i);
      failures++;
      end_sim();
   end

   // Main sequence
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk("idle line", 32'h1, {31'h0, txd_o});
      chk("stop at reset", 32'h1, {31'h0, stop_o});
      chk("width at reset", 32'h0, {24'h0, pulse_width_o});
      for (int i = 0; i < 24; i++) begin
         cmd(8'(i * 11), rows[i][31:24], rows[i][23:16], rows[i][15:8], rows[i][7:0], 9);
      end
      chk("outputs", 32'h05c00101,
          {dead_time_o, pulse_width_o, 8'(res7_o), 3'h0, stop_o, 3'h0, clk_div2_o});
      chk("lock sel", 32'h1, {30'h0, lock_o, clk_sel_uproc_o});
      chk("made clock gap", 32'h1, {31'h0, (ugap_last == UGAP || ugap_last == UGAP + 1)});
      wb(1'b0, 8'h0c, 32'h0);
      chk("settings", 32'hc0053217, q);
      // Clock enable low freezes the bus slave until it returns
      ce_i <= 1'b0;
      fork
         wb(1'b0, 8'h0c, 32'h0);
         begin
            repeat (6) @(posedge clk_i);
            chk("frozen ack", 32'h0, {31'h0, wb_ack_o});
            ce_i <= 1'b1;
         end
      join
      chk("settings after freeze", 32'hc0053217, q);
      wb(1'b1, 8'h04, 32'h7);
      wb(1'b0, 8'h00, 32'h0);
      chk("status", 32'h3, q);
      chk("irq set", 32'h1, {31'h0, irq_o});
      wb(1'b1, 8'h08, 32'h3);
      wb(1'b0, 8'h00, 32'h0);
      chk("status clr", 32'h0, q);
      chk("irq clr", 32'h0, {31'h0, irq_o});
      wb(1'b0, 8'h10, 32'h0);
      chk("unmapped", 32'h0, q);
      wb(1'b0, 8'h04, 32'h0);
      chk("enable reg", 32'h7, q);
      // Wrong terminator is dropped and flagged
      no_reply({8'h02, 8'h00, 8'h20, 8'h11, 8'h0b});
      chk("width kept", 32'hc0, {24'h0, pulse_width_o});
      wb(1'b0, 8'h00, 32'h0);
      chk("drop flag", 32'h4, q);
      chk("irq drop", 32'h1, {31'h0, irq_o});
      wb(1'b1, 8'h04, 32'h0);
      chk("irq masked", 32'h0, {31'h0, irq_o});
      wb(1'b1, 8'h08, 32'h4);
      // Wrong board address is ignored, the next packet is served
      no_reply({8'h01, 8'h00, 8'h20, 8'h11, 8'h0a});
      cmd(8'h00, 8'h90, 8'h00, 8'hc0, 8'h00, 9);
      // Framing fault on the opcode byte
      cmd(8'h05, 8'h20, 8'h12, 8'h00, 8'he1, 2);
      // Stray byte while a reply is sent poisons the next reply
      fork
         cmd(8'h00, 8'h93, 8'h00, 8'h01, 8'h00, 9);
         begin
            for (int n = 0; n < BIT * 64 && txd_o !== 1'b0; n++) @(posedge clk_i);
            repeat (BIT * 3) @(posedge clk_i);
            i_serial_host.send_byte(8'h55, 1'b1);
         end
      join
      cmd(8'h00, 8'h90, 8'h00, 8'hc0, 8'he0, 9);
      // Board reset clears the lock and all settings
      cmd(8'hff, 8'h70, 8'h01, 8'h01, 8'h00, 9);
      cmd(8'hff, 8'h50, 8'h00, 8'h00, 8'h00, 9);
      chk("reset lock", 32'h0, {31'h0, lock_o});
      chk("reset width", 32'h0, {24'h0, pulse_width_o});
      chk("reset stop", 32'h1, {31'h0, stop_o});
      chk("reset dead", 32'h0, {24'h0, dead_time_o});
      chk("reset made clock", 32'h0, {31'h0, uproc_clk_o});
      end_sim();
   end
endmodule
